//--- shared/pacr_pkg.sv
// package with register map, field positions and reset values for the address/config bank
package pacr_pkg;
    localparam int REG_AW = 5;
    localparam int REG_DW = 16;
    localparam logic [4:0] ADDR_STATUS_OFS = 5'h19;
    localparam logic [4:0] TEN_STATUS_OFS = 5'h1b;
    localparam logic [4:0] TEN_CONFIG_OFS = 5'h1c;
    // address/status fields
    localparam int SPEED_BIT = 6;
    localparam int CONNECT_BIT = 5;
    localparam int ADDR_MSB = 4;
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_ISOLATE_VAL = 5'h00;
    // tenbase status fields
    localparam int SERIAL_BIT = 9;
    // tenbase config fields
    localparam int LINK_PULSE_BIT = 5;
    localparam int HEARTBEAT_BIT = 4;
    localparam int PAIR_SEL_BIT = 3;
    localparam int LOW_SQUELCH_BIT = 2;
    localparam int JABBER_BIT = 0;
    localparam logic [5:0] TEN_CONFIG_RST = 6'h39;
    localparam logic [5:0] TEN_CONFIG_WMASK = 6'h3d;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    // strap capture states
    typedef enum logic [2:0] {
        PACR_ST_RESET = 3'b001,
        PACR_ST_SAMPLE = 3'b010,
        PACR_ST_RUN = 3'b100
    } pacr_state_t;
endpackage

//--- logic/pacr_sync3.sv
// three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pacr_sync3 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pin side and result
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] level_ff;

    // elaboration check: at least one bit must be synchronised
    if (WIDTH < 1) begin : g_width_check
        $error("pacr_sync3: WIDTH must be positive");
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    level_ff[i] <= 1'b0;
                end else if (s2_ff[i] == s3_ff[i]) begin
                    level_ff[i] <= s3_ff[i];
                end
            end
        end
    endgenerate

    assign level = level_ff;
endmodule
`default_nettype wire

//--- logic/pacr_pair_drv.sv
// transmit pair steering: the selected pair drives, the other is released
`timescale 1ns/10ps
`default_nettype none
module pacr_pair_drv (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // selection and line data
    input wire logic unshielded_sel,
    input wire logic tx_data,
    // unshielded pair
    output logic unshielded_tx_pair_o,
    output logic unshielded_tx_pair_oe,
    // shielded pair
    output logic shielded_tx_pair_o,
    output logic shielded_tx_pair_oe
);
    logic data_ff;
    logic utp_oe_ff;
    logic stp_oe_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_ff <= 1'b0;
        end else begin
            data_ff <= tx_data;
        end
    end

    // only one pair enabled at a time
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            utp_oe_ff <= 1'b0;
            stp_oe_ff <= 1'b0;
        end else begin
            utp_oe_ff <= unshielded_sel;
            stp_oe_ff <= ~unshielded_sel;
        end
    end

    assign unshielded_tx_pair_o = data_ff;
    assign shielded_tx_pair_o = data_ff;
    assign unshielded_tx_pair_oe = utp_oe_ff;
    assign shielded_tx_pair_oe = stp_oe_ff;

    property p_one_pair;
        @(posedge clk_sys) disable iff (!rst_n)
        !(utp_oe_ff && stp_oe_ff);
    endproperty
    a_one_pair: assert property (p_one_pair) else $error("both transmit pairs enabled");
endmodule
`default_nettype wire

//--- logic/pacr_regs.sv
// address/status, tenbase status and tenbase configuration registers
`timescale 1ns/10ps
`default_nettype none
module pacr_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // management register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pacr_pkg::REG_AW-1:0] reg_addr,
    input wire logic [pacr_pkg::REG_DW-1:0] reg_wdata,
    output logic [pacr_pkg::REG_DW-1:0] reg_rdata,
    output logic reg_hit,
    // strap pins
    input wire logic [pacr_pkg::ADDR_W-1:0] station_address_straps,
    input wire logic serial_data_strap,
    // state from the rest of the device
    input wire logic link_valid,
    input wire logic speed_100_cfg,
    input wire logic autoneg_en,
    input wire logic full_duplex,
    input wire logic endec_loopback_bit,
    input wire logic indicator_select_bit,
    input wire logic indicator_normal,
    input wire logic tx_data,
    // controls to the rest of the device
    output logic isolate_set,
    output logic speed_10_mode,
    output logic link_pulse_tx_en,
    output logic force_good_link,
    output logic heartbeat_active,
    output logic low_squelch_select,
    output logic jabber_active,
    output logic serial_data_select,
    output logic [pacr_pkg::ADDR_W-1:0] station_address_field,
    // indicator and transmit pairs
    output logic first_indicator_pin,
    output logic unshielded_tx_pair_o,
    output logic unshielded_tx_pair_oe,
    output logic shielded_tx_pair_o,
    output logic shielded_tx_pair_oe
);
    import pacr_pkg::*;

    pacr_state_t state_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic serial_ff;
    logic [5:0] cfg_ff;
    logic connect_state_flag;
    logic connect_ff;
    logic speed10_ff;
    logic [REG_DW-1:0] rdata_ff;
    logic [ADDR_W-1:0] straps_sync;
    logic serial_sync;
    logic link_sync;
    logic [REG_DW-1:0] nxt_rdata;
    logic nxt_hit;
    logic wr_addr;
    logic wr_ten_status;
    logic wr_ten_config;
    logic nxt_speed10;

    pacr_sync3 #(.WIDTH(ADDR_W + 2)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin({station_address_straps, serial_data_strap, link_valid}),
        .level({straps_sync, serial_sync, link_sync})
    );

    // strap capture waits for the synchroniser to settle after reset release
    logic [1:0] settle_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= PACR_ST_RESET;
            settle_ff <= 2'h0;
        end else begin
            case (state_ff)
                PACR_ST_RESET: begin
                    settle_ff <= settle_ff + 2'h1;
                    if (settle_ff == 2'h3) begin
                        state_ff <= PACR_ST_SAMPLE;
                    end
                end
                PACR_ST_SAMPLE: state_ff <= PACR_ST_RUN;
                PACR_ST_RUN: state_ff <= PACR_ST_RUN;
                default: state_ff <= PACR_ST_RESET;
            endcase
        end
    end

    assign wr_addr = reg_wr && (reg_addr == ADDR_STATUS_OFS);
    assign wr_ten_status = reg_wr && (reg_addr == TEN_STATUS_OFS);
    assign wr_ten_config = reg_wr && (reg_addr == TEN_CONFIG_OFS);

    // station address: strap load then software writable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= '0;
        end else if (state_ff == PACR_ST_SAMPLE) begin
            addr_ff <= straps_sync;
        end else if (wr_addr) begin
            addr_ff <= reg_wdata[ADDR_MSB:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serial_ff <= 1'b0;
        end else if (state_ff == PACR_ST_SAMPLE) begin
            serial_ff <= serial_sync;
        end else if (wr_ten_status) begin
            serial_ff <= reg_wdata[SERIAL_BIT];
        end
    end

    // only documented writable bits take data; reserved bit 1 stays zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= TEN_CONFIG_RST;
        end else if (wr_ten_config) begin
            cfg_ff <= reg_wdata[5:0] & TEN_CONFIG_WMASK;
        end
    end

    // connect status: forced good link when link pulses are off
    assign connect_state_flag = link_sync || !cfg_ff[LINK_PULSE_BIT];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            connect_ff <= 1'b0;
        end else begin
            connect_ff <= connect_state_flag;
        end
    end

    // speed: link pulse clear under auto-negotiation falls back to 10 Mb/s
    always_comb begin
        nxt_speed10 = !speed_100_cfg;
        if (speed_100_cfg && autoneg_en && !cfg_ff[LINK_PULSE_BIT]) begin
            nxt_speed10 = 1'b1;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            speed10_ff <= 1'b0;
        end else begin
            speed10_ff <= nxt_speed10;
        end
    end

    // read mux, registered; reserved bits zero
    always_comb begin
        nxt_rdata = ZERO_WORD;
        nxt_hit = 1'b1;
        if (reg_addr == ADDR_STATUS_OFS) begin
            nxt_rdata[SPEED_BIT] = speed10_ff;
            nxt_rdata[CONNECT_BIT] = connect_ff;
            nxt_rdata[ADDR_MSB:0] = addr_ff;
        end else if (reg_addr == TEN_STATUS_OFS) begin
            nxt_rdata[SERIAL_BIT] = serial_ff;
        end else if (reg_addr == TEN_CONFIG_OFS) begin
            nxt_rdata[5:0] = cfg_ff;
        end else begin
            nxt_hit = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= ZERO_WORD;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;
    assign reg_hit = nxt_hit;

    // controls
    assign station_address_field = addr_ff;
    assign isolate_set = (state_ff == PACR_ST_RUN) && (addr_ff == ADDR_ISOLATE_VAL);
    assign speed_10_mode = speed10_ff;
    assign link_pulse_tx_en = cfg_ff[LINK_PULSE_BIT];
    assign force_good_link = !cfg_ff[LINK_PULSE_BIT];
    assign heartbeat_active = cfg_ff[HEARTBEAT_BIT] && !full_duplex;
    assign low_squelch_select = cfg_ff[LOW_SQUELCH_BIT];
    assign jabber_active = cfg_ff[JABBER_BIT] && (full_duplex || endec_loopback_bit);
    assign serial_data_select = serial_ff && speed10_ff;
    assign first_indicator_pin = indicator_select_bit ? connect_ff : indicator_normal;

    pacr_pair_drv u_pair (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .unshielded_sel(cfg_ff[PAIR_SEL_BIT]),
        .tx_data(tx_data),
        .unshielded_tx_pair_o(unshielded_tx_pair_o),
        .unshielded_tx_pair_oe(unshielded_tx_pair_oe),
        .shielded_tx_pair_o(shielded_tx_pair_o),
        .shielded_tx_pair_oe(shielded_tx_pair_oe)
    );

    property p_cfg_write;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_ten_config |=> cfg_ff == ($past(reg_wdata[5:0]) & TEN_CONFIG_WMASK);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_isolate;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_ff == PACR_ST_RUN && wr_addr && reg_wdata[ADDR_MSB:0] == ADDR_ISOLATE_VAL)
            |=> isolate_set;
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolate not set");

    property p_strap_load;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_ff == PACR_ST_SAMPLE) |=> addr_ff == $past(straps_sync)
            && serial_ff == $past(serial_sync);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("straps not loaded");

    property p_fallback;
        @(posedge clk_sys) disable iff (!rst_n)
        (speed_100_cfg && autoneg_en && !cfg_ff[LINK_PULSE_BIT]) |=> speed10_ff;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no 10 Mb/s fallback");

    property p_fixed100;
        @(posedge clk_sys) disable iff (!rst_n)
        (speed_100_cfg && !autoneg_en) |=> !speed10_ff;
    endproperty
    a_fixed100: assert property (p_fixed100) else $error("fixed 100 changed");

    property p_heartbeat;
        @(posedge clk_sys) disable iff (!rst_n)
        full_duplex |-> !heartbeat_active;
    endproperty
    a_heartbeat: assert property (p_heartbeat) else $error("heartbeat in duplex");

    property p_indicator;
        @(posedge clk_sys) disable iff (!rst_n)
        indicator_select_bit |-> first_indicator_pin == connect_ff;
    endproperty
    a_indicator: assert property (p_indicator) else $error("indicator wrong");

    property p_connect;
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_ff[LINK_PULSE_BIT] ##1 !cfg_ff[LINK_PULSE_BIT] |-> connect_ff;
    endproperty
    a_connect: assert property (p_connect) else $error("forced link missing");

    property p_pair;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(cfg_ff[PAIR_SEL_BIT]) |=> unshielded_tx_pair_oe && !shielded_tx_pair_oe;
    endproperty
    a_pair: assert property (p_pair) else $error("pair select wrong");

    property p_jabber;
        @(posedge clk_sys) disable iff (!rst_n)
        (!full_duplex && !endec_loopback_bit) |-> !jabber_active;
    endproperty
    a_jabber: assert property (p_jabber) else $error("jabber outside mode");
endmodule
`default_nettype wire

//--- verif/pacr_mgmt_model.sv
// management entity model driving the register strobes
`timescale 1ns/10ps
`default_nettype none
module pacr_mgmt_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [pacr_pkg::REG_AW-1:0] reg_addr,
    output logic [pacr_pkg::REG_DW-1:0] reg_wdata,
    input wire logic [pacr_pkg::REG_DW-1:0] reg_rdata
);
    import pacr_pkg::*;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
    end
    // one-cycle strobe; released data flips so stale values never match
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // data is taken one cycle after the strobe edge
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- verif/phy_addr_tenbase_cfg_regs_bench.sv
// self-checking bench for the address/status and tenbase register bank
`timescale 1ns/10ps
`default_nettype none
module phy_addr_tenbase_cfg_regs_bench;
    import pacr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, reg_hit, serial_data_strap, link_valid, speed_100_cfg;
    logic autoneg_en, full_duplex, endec_loopback_bit, indicator_select_bit;
    logic indicator_normal, tx_data, isolate_set, speed_10_mode, link_pulse_tx_en;
    logic force_good_link, heartbeat_active, low_squelch_select, jabber_active;
    logic serial_data_select, first_indicator_pin, unshielded_tx_pair_o;
    logic unshielded_tx_pair_oe, shielded_tx_pair_o, shielded_tx_pair_oe;
    logic [4:0] reg_addr, station_address_straps, station_address_field;
    logic [15:0] reg_wdata, reg_rdata, d;
    int n_errors = 0;
    int checks = 0;
    always #50 clk_sys = ~clk_sys;
    pacr_mgmt_model mgr (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    pacr_regs dut (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_hit, .station_address_straps, .serial_data_strap,
        .link_valid, .speed_100_cfg, .autoneg_en, .full_duplex, .endec_loopback_bit,
        .indicator_select_bit, .indicator_normal, .tx_data, .isolate_set,
        .speed_10_mode, .link_pulse_tx_en, .force_good_link, .heartbeat_active,
        .low_squelch_select, .jabber_active, .serial_data_select,
        .station_address_field, .first_indicator_pin, .unshielded_tx_pair_o,
        .unshielded_tx_pair_oe, .shielded_tx_pair_o, .shielded_tx_pair_oe);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_reset();
        mgr.rd(ADDR_STATUS_OFS, d);
        chk(d, 16'h0076, "addr reset");
        mgr.rd(TEN_STATUS_OFS, d);
        chk(d, 16'h0200, "serial strap");
        mgr.rd(TEN_CONFIG_OFS, d);
        chk(d, 16'h0039, "cfg reset");
        chk(16'({unshielded_tx_pair_oe, shielded_tx_pair_oe}), 16'h2, "utp oe");
        chk(16'(serial_data_select), 16'h1, "serial sel");
    endtask
    task automatic t_cfg();
        mgr.wr(TEN_CONFIG_OFS, 16'hffff);
        mgr.rd(TEN_CONFIG_OFS, d);
        chk(d, 16'h003d, "cfg ones");
        chk(16'({low_squelch_select, heartbeat_active, jabber_active}), 16'h6, "ls");
        full_duplex <= 1'b1;
        cyc(2);
        chk(16'({heartbeat_active, jabber_active}), 16'h1, "fdx");
        full_duplex <= 1'b0;
        endec_loopback_bit <= 1'b1;
        tx_data <= 1'b1;
        cyc(2);
        chk(16'(jabber_active), 16'h1, "lpbk jab");
        mgr.wr(TEN_CONFIG_OFS, 16'h0000);
        cyc(3);
        chk(16'({link_pulse_tx_en, force_good_link, heartbeat_active, jabber_active}),
            16'h4, "cfg zero");
        chk(16'({unshielded_tx_pair_oe, shielded_tx_pair_oe, shielded_tx_pair_o}),
            16'h3, "stp");
        chk(16'(unshielded_tx_pair_o), 16'h1, "utp data");
    endtask
    task automatic t_speed();
        link_valid <= 1'b0;
        speed_100_cfg <= 1'b1;
        autoneg_en <= 1'b1;
        indicator_select_bit <= 1'b1;
        cyc(6);
        mgr.rd(ADDR_STATUS_OFS, d);
        chk(d, 16'h0076, "lp off");
        chk(16'(first_indicator_pin), 16'h1, "ind con");
        chk(16'(speed_10_mode), 16'h1, "spd fallback");
        autoneg_en <= 1'b0;
        cyc(3);
        mgr.rd(ADDR_STATUS_OFS, d);
        chk(d, 16'h0036, "fixed 100");
        chk(16'(serial_data_select), 16'h0, "ser 100");
        chk(16'(speed_10_mode), 16'h0, "spd fixed");
        mgr.wr(TEN_CONFIG_OFS, 16'h0039);
        autoneg_en <= 1'b1;
        cyc(3);
        mgr.rd(ADDR_STATUS_OFS, d);
        chk(d, 16'h0016, "no link");
        chk(16'(first_indicator_pin), 16'h0, "ind off");
        indicator_select_bit <= 1'b0;
        indicator_normal <= 1'b1;
        link_valid <= 1'b1;
        speed_100_cfg <= 1'b0;
        cyc(6);
        mgr.rd(ADDR_STATUS_OFS, d);
        chk(d, 16'h0076, "link 10");
        chk(16'(first_indicator_pin), 16'h1, "ind norm");
    endtask
    task automatic t_addr();
        mgr.wr(ADDR_STATUS_OFS, 16'hffe0);
        mgr.rd(ADDR_STATUS_OFS, d);
        chk(d, 16'h0060, "addr zero");
        chk(16'({isolate_set, station_address_field}), 16'h20, "iso");
        mgr.wr(ADDR_STATUS_OFS, 16'h0011);
        mgr.rd(ADDR_STATUS_OFS, d);
        chk(d, 16'h0071, "addr set");
        chk(16'({isolate_set, station_address_field}), 16'h11, "no iso");
    endtask
    task automatic t_unmapped();
        mgr.rd(5'h00, d);
        chk(d, 16'h0000, "unmapped rd");
        chk(16'(reg_hit), 16'h0, "no hit");
        mgr.wr(5'h1a, 16'hffff);
        mgr.rd(TEN_CONFIG_OFS, d);
        chk(d, 16'h0039, "unmapped wr");
        chk(16'(reg_hit), 16'h1, "hit");
    endtask
    initial begin
        cyc(20000);
        n_errors++;
        print_verdict();
    end
    initial begin
        station_address_straps = 5'h16;
        serial_data_strap = 1'b1;
        link_valid = 1'b1;
        speed_100_cfg = 1'b0;
        autoneg_en = 1'b0;
        full_duplex = 1'b0;
        endec_loopback_bit = 1'b0;
        indicator_select_bit = 1'b0;
        indicator_normal = 1'b0;
        tx_data = 1'b0;
        cyc(12);
        rst_n <= 1'b1;
        cyc(8);
        t_reset();
        t_cfg();
        t_speed();
        t_addr();
        t_unmapped();
        print_verdict();
    end
endmodule
`default_nettype wire
